//--- hw/cmf_pkg.sv
// constants and types shared by the cache miss fill and write buffer logic
// Overview of operation
// - read miss fetches memory, feeds processor and cache
// - missed word goes to bypass buffer at once
// - processor continues right after the missed word
// - block collects in load buffer, written when complete
// - later fill word: forward if present, else stall
// - one address per sixteen-byte block transfer
// - sixteen-byte block, four words per burst
// - writes buffered at cache speed, memory write concurrent
// - address splits into tag and set; compare tags
// - fetched block stored with its new tag
package cmf_pkg;

  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int BLOCK_BYTES = 16;
  localparam int WORD_BYTES  = 4;
  localparam int WORDS       = BLOCK_BYTES / WORD_BYTES;
  localparam int OFF_W       = 4;
  localparam int WSEL_W      = 2;
  localparam int WSEL_LSB    = 2;
  localparam int IDX_W       = 4;
  localparam int SETS        = 16;
  localparam int IDX_LSB     = OFF_W;
  localparam int TAG_LSB     = OFF_W + IDX_W;
  localparam int TAG_W       = ADDR_W - TAG_LSB;
  localparam int LINE_W      = DATA_W * WORDS;
  localparam int BLK_W       = ADDR_W - OFF_W;

  // write buffer: address and data travel together
  localparam int WBUF_DEPTH  = 16;
  localparam int WBUF_W      = ADDR_W + DATA_W;
  localparam int WBUF_CNT_W  = 5;

  // forwarding of already filled words from the load buffer
  localparam logic FWD_EN    = 1'b1;

  localparam logic [OFF_W-1:0] BLK_OFF_ZERO = 4'h0;
  localparam logic [WORDS-1:0] MASK_FULL    = 4'hF;
  localparam logic [WSEL_W-1:0] LAST_BEAT   = 2'h3;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_DRAIN = 2'b01,
    ST_REQ   = 2'b10,
    ST_FILL  = 2'b11
  } cmf_state_t;

endpackage : cmf_pkg

//--- hw/cmf_fifo.sv
// write buffer fifo with a registered output stage
`timescale 1ns/1ps
`default_nettype none
module cmf_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         in_valid,
  input  wire logic [WIDTH-1:0]             in_data,
  output var  logic                         in_ready,
  output var  logic                         out_valid,
  output var  logic [WIDTH-1:0]             out_data,
  input  wire logic                         out_ready,
  output var  logic [$clog2(DEPTH+1)-1:0]   count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [CW-1:0]               cnt;
    logic                        in_rdy;
    logic                        o_v;
    logic [WIDTH-1:0]            o_d;
  } cmf_fifo_t;

  cmf_fifo_t fifo_reg;
  cmf_fifo_t fifo_next;
  logic      push;
  logic      load;

  always_comb
  begin
    fifo_next = fifo_reg;
    push      = in_valid && fifo_reg.in_rdy;
    load      = (!fifo_reg.o_v || out_ready) && (fifo_reg.cnt != '0);
    if (fifo_reg.o_v && out_ready)
    begin
      fifo_next.o_v = 1'b0;
    end
    if (load)
    begin
      fifo_next.o_v = 1'b1;
      fifo_next.o_d = fifo_reg.mem[fifo_reg.rd];
      fifo_next.rd  = (fifo_reg.rd == AW'(DEPTH-1)) ? '0 : fifo_reg.rd + 1'b1;
    end
    if (push)
    begin
      fifo_next.mem[fifo_reg.wr] = in_data;
      fifo_next.wr = (fifo_reg.wr == AW'(DEPTH-1)) ? '0 : fifo_reg.wr + 1'b1;
    end
    fifo_next.cnt    = fifo_reg.cnt + CW'(push) - CW'(load);
    // ready is registered, so it looks at the count after this cycle
    fifo_next.in_rdy = fifo_next.cnt < CW'(DEPTH);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fifo_reg <= '0;
    else
      fifo_reg <= fifo_next;
  end

  assign in_ready  = fifo_reg.in_rdy;
  assign out_valid = fifo_reg.o_v;
  assign out_data  = fifo_reg.o_d;
  assign count     = fifo_reg.cnt;

  fifo_full_a : assert property (@(posedge clk) disable iff (!nrst)
    (fifo_reg.cnt == CW'(DEPTH)) |-> !in_ready && !$past(in_ready) || $past(push))
    else $error("fifo ready while full");

endmodule : cmf_fifo
`default_nettype wire

//--- hw/cmf_tag_dir.sv
// tag directory and data array of the direct mapped cache
`timescale 1ns/1ps
`default_nettype none
module cmf_tag_dir
  import cmf_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic [cmf_pkg::IDX_W-1:0]  rd_idx,
  output var  logic                       rd_valid,
  output var  logic [cmf_pkg::TAG_W-1:0]  rd_tag,
  output var  logic [cmf_pkg::LINE_W-1:0] rd_data,
  input  wire logic                       wr_en,
  input  wire logic [cmf_pkg::IDX_W-1:0]  wr_idx,
  input  wire logic [cmf_pkg::TAG_W-1:0]  wr_tag,
  input  wire logic [cmf_pkg::WORDS-1:0]  wr_mask,
  input  wire logic [cmf_pkg::LINE_W-1:0] wr_data
);
  typedef struct packed {
    logic [SETS-1:0]             valid;
    logic [SETS-1:0][TAG_W-1:0]  tag;
    logic [SETS-1:0][LINE_W-1:0] data;
  } cmf_dir_t;

  cmf_dir_t dir_reg;
  cmf_dir_t dir_next;

  always_comb
  begin
    dir_next = dir_reg;
    if (wr_en)
    begin
      for (int w = 0; w < WORDS; w++)
      begin
        if (wr_mask[w])
          dir_next.data[wr_idx][w*DATA_W +: DATA_W] = wr_data[w*DATA_W +: DATA_W];
      end
      // only a whole block installs a new tag
      if (wr_mask == MASK_FULL)
      begin
        dir_next.tag[wr_idx]   = wr_tag;
        dir_next.valid[wr_idx] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dir_reg <= '0;
    else
      dir_reg <= dir_next;
  end

  assign rd_valid = dir_reg.valid[rd_idx];
  assign rd_tag   = dir_reg.tag[rd_idx];
  assign rd_data  = dir_reg.data[rd_idx];

  new_tag_a : assert property (@(posedge clk) disable iff (!nrst)
    (wr_en && wr_mask == MASK_FULL) |=> dir_reg.valid[$past(wr_idx)]
      && dir_reg.tag[$past(wr_idx)] == $past(wr_tag)
      && dir_reg.data[$past(wr_idx)] == $past(wr_data))
    else $error("filled block not stored with its tag");

endmodule : cmf_tag_dir
`default_nettype wire

//--- hw/cmf_cache_fill.sv
// miss handling, fetch bypass, wraparound load and buffered writes of the cache
`timescale 1ns/1ps
`default_nettype none
module cmf_cache_fill
  import cmf_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        cpu_req_valid,
  input  wire logic                        cpu_req_write,
  input  wire logic [cmf_pkg::ADDR_W-1:0]  cpu_req_addr,
  input  wire logic [cmf_pkg::DATA_W-1:0]  cpu_req_wdata,
  output var  logic                        cpu_req_ready,
  output var  logic                        cpu_rsp_valid,
  output var  logic [cmf_pkg::DATA_W-1:0]  cpu_rsp_rdata,
  output var  logic                        mem_rd_req,
  output var  logic [cmf_pkg::ADDR_W-1:0]  mem_rd_addr,
  output var  logic [cmf_pkg::WSEL_W-1:0]  mem_rd_word,
  input  wire logic                        mem_rd_ack,
  input  wire logic                        mem_rd_valid,
  input  wire logic [cmf_pkg::DATA_W-1:0]  mem_rd_data,
  output var  logic                        mem_wr_valid,
  output var  logic [cmf_pkg::ADDR_W-1:0]  mem_wr_addr,
  output var  logic [cmf_pkg::DATA_W-1:0]  mem_wr_data,
  input  wire logic                        mem_wr_ready
);
  import cmf_pkg::*;

  typedef struct packed {
    cmf_state_t              st;
    logic                    req_ready;
    logic                    rsp_valid;
    logic [DATA_W-1:0]       byp;
    logic                    rd_req;
    logic [ADDR_W-1:0]       miss_addr;
    logic [WSEL_W-1:0]       beat;
    logic [LINE_W-1:0]       lbuf;
    logic [WORDS-1:0]        lmask;
    logic                    pend_v;
    logic                    pend_we;
    logic [ADDR_W-1:0]       pend_addr;
    logic [DATA_W-1:0]       pend_wdata;
  } cmf_top_t;

  cmf_top_t               top_reg;
  cmf_top_t               top_next;

  logic                   use_pend;
  logic                   take_cpu;
  logic                   c_v;
  logic                   c_we;
  logic [ADDR_W-1:0]      c_addr;
  logic [DATA_W-1:0]      c_wdata;
  logic [WSEL_W-1:0]      c_word;
  logic                   hit;
  logic                   fill_match;
  logic                   beat_v;
  logic [WSEL_W-1:0]      bw;
  logic                   wb_push;
  logic                   wb_in_ready;
  logic                   wb_out_valid;
  logic [WBUF_W-1:0]      wb_out_data;
  logic [WBUF_CNT_W-1:0]  wb_cnt;
  logic                   wb_busy;
  logic                   dir_rd_valid;
  logic [TAG_W-1:0]       dir_rd_tag;
  logic [LINE_W-1:0]      dir_rd_data;
  logic                   dir_wr_en;
  logic [WORDS-1:0]       dir_wr_mask;
  logic [LINE_W-1:0]      dir_wr_data;
  logic                   fwd_take;

  // a queued request replays in idle before any new one is taken
  assign use_pend   = top_reg.pend_v && (top_reg.st == ST_IDLE);
  assign take_cpu   = cpu_req_valid && top_reg.req_ready;
  assign c_v        = use_pend || take_cpu;
  assign c_we       = use_pend ? top_reg.pend_we : cpu_req_write;
  assign c_addr     = use_pend ? top_reg.pend_addr : cpu_req_addr;
  assign c_wdata    = use_pend ? top_reg.pend_wdata : cpu_req_wdata;
  assign c_word     = c_addr[WSEL_LSB +: WSEL_W];
  assign hit        = dir_rd_valid && (dir_rd_tag == c_addr[TAG_LSB +: TAG_W]);
  assign fill_match = (top_reg.st == ST_FILL) && (c_addr[OFF_W +: BLK_W] == top_reg.miss_addr[OFF_W +: BLK_W]);
  assign beat_v     = (top_reg.st == ST_FILL) && mem_rd_valid;
  // words come back starting at the missed one and wrap inside the block
  assign bw         = top_reg.miss_addr[WSEL_LSB +: WSEL_W] + top_reg.beat;
  assign wb_busy    = (wb_cnt != '0) || wb_out_valid;
  assign fwd_take   = take_cpu && !c_we && fill_match && FWD_EN && top_reg.lmask[c_word];

  cmf_tag_dir u_dir (
    .clk      (clk),
    .nrst     (nrst),
    .rd_idx   (c_addr[IDX_LSB +: IDX_W]),
    .rd_valid (dir_rd_valid),
    .rd_tag   (dir_rd_tag),
    .rd_data  (dir_rd_data),
    .wr_en    (dir_wr_en),
    .wr_idx   (top_reg.st == ST_FILL ? top_reg.miss_addr[IDX_LSB +: IDX_W] : c_addr[IDX_LSB +: IDX_W]),
    .wr_tag   (top_reg.miss_addr[TAG_LSB +: TAG_W]),
    .wr_mask  (dir_wr_mask),
    .wr_data  (dir_wr_data)
  );

  cmf_fifo #(
    .WIDTH (WBUF_W),
    .DEPTH (WBUF_DEPTH)
  ) u_wbuf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (wb_push),
    .in_data   ({c_addr, c_wdata}),
    .in_ready  (wb_in_ready),
    .out_valid (wb_out_valid),
    .out_data  (wb_out_data),
    .out_ready (mem_wr_ready),
    .count     (wb_cnt)
  );

  always_comb
  begin
    top_next           = top_reg;
    top_next.rsp_valid = 1'b0;
    wb_push            = 1'b0;
    dir_wr_en          = 1'b0;
    dir_wr_mask        = '0;
    dir_wr_data        = {WORDS{c_wdata}};
    if (use_pend)
      top_next.pend_v = 1'b0;
    case (top_reg.st)
      ST_IDLE:
      begin
        if (c_v && c_we)
        begin
          // write goes to the buffer; the processor is not held for memory
          wb_push = 1'b1;
          if (hit)
          begin
            dir_wr_en           = 1'b1;
            dir_wr_mask[c_word] = 1'b1;
          end
        end
        else if (c_v && hit)
        begin
          top_next.rsp_valid = 1'b1;
          top_next.byp       = dir_rd_data[c_word*DATA_W +: DATA_W];
        end
        else if (c_v)
        begin
          // a read miss waits for queued writes so memory is never stale
          top_next.miss_addr = c_addr;
          top_next.beat      = '0;
          top_next.lmask     = '0;
          top_next.st        = wb_busy ? ST_DRAIN : ST_REQ;
          top_next.rd_req    = !wb_busy;
        end
      end
      ST_DRAIN:
      begin
        if (!wb_busy)
        begin
          top_next.st     = ST_REQ;
          top_next.rd_req = 1'b1;
        end
      end
      ST_REQ:
      begin
        // a single block address starts the whole burst
        if (mem_rd_ack)
        begin
          top_next.rd_req = 1'b0;
          top_next.st     = ST_FILL;
        end
      end
      ST_FILL:
      begin
        if (beat_v)
        begin
          top_next.lbuf[bw*DATA_W +: DATA_W] = mem_rd_data;
          top_next.lmask[bw]                 = 1'b1;
          top_next.beat                      = top_reg.beat + 1'b1;
          if (top_reg.beat == '0)
          begin
            top_next.rsp_valid = 1'b1;
            top_next.byp       = mem_rd_data;
          end
          if (top_reg.beat == LAST_BEAT)
          begin
            dir_wr_en   = 1'b1;
            dir_wr_mask = MASK_FULL;
            top_next.st = ST_IDLE;
          end
        end
        if (fwd_take)
        begin
          top_next.rsp_valid = 1'b1;
          top_next.byp       = top_reg.lbuf[c_word*DATA_W +: DATA_W];
        end
        else if (take_cpu && !c_we && !fill_match && hit)
        begin
          top_next.rsp_valid = 1'b1;
          top_next.byp       = dir_rd_data[c_word*DATA_W +: DATA_W];
        end
        else if (take_cpu)
        begin
          // anything else waits until the block is in the array
          top_next.pend_v     = 1'b1;
          top_next.pend_we    = c_we;
          top_next.pend_addr  = c_addr;
          top_next.pend_wdata = c_wdata;
        end
      end
      default:
      begin
        top_next.st = ST_IDLE;
      end
    endcase
    if (top_reg.st == ST_FILL)
      dir_wr_data = top_next.lbuf;
    // ready returns once the missed word is out, not after the array update
    top_next.req_ready = ((top_next.st == ST_IDLE) || (top_next.st == ST_FILL && top_next.lmask != '0))
      && !top_next.pend_v && ((int'(wb_cnt) + int'(wb_push)) < WBUF_DEPTH);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      top_reg <= '0;
    else
      top_reg <= top_next;
  end

  assign cpu_req_ready = top_reg.req_ready;
  assign cpu_rsp_valid = top_reg.rsp_valid;
  assign cpu_rsp_rdata = top_reg.byp;
  assign mem_rd_req    = top_reg.rd_req;
  assign mem_rd_addr   = {top_reg.miss_addr[OFF_W +: BLK_W], BLK_OFF_ZERO};
  assign mem_rd_word   = top_reg.miss_addr[WSEL_LSB +: WSEL_W];
  assign mem_wr_valid  = wb_out_valid;
  assign mem_wr_addr   = wb_out_data[DATA_W +: ADDR_W];
  assign mem_wr_data   = wb_out_data[DATA_W-1:0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  miss_starts_a : assert property ((top_reg.st == ST_IDLE && c_v && !c_we && !hit)
    |=> (top_reg.st == ST_DRAIN || top_reg.st == ST_REQ) && top_reg.miss_addr == $past(c_addr))
    else $error("read miss did not start a fill");

  bypass_word_a : assert property ((beat_v && top_reg.beat == '0)
    |=> cpu_rsp_valid && cpu_rsp_rdata == $past(mem_rd_data))
    else $error("missed word not delivered from bypass");

  early_release_a : assert property ((beat_v && top_reg.beat == '0 && wb_cnt < 5'h0F)
    |=> cpu_req_ready && top_reg.st == ST_FILL)
    else $error("processor held after missed word");

  whole_block_a : assert property ((dir_wr_en && dir_wr_mask == MASK_FULL)
    |-> beat_v && top_reg.beat == LAST_BEAT && top_next.lmask == MASK_FULL)
    else $error("array written before block complete");

  forward_word_a : assert property (fwd_take
    |=> cpu_rsp_valid && cpu_rsp_rdata == $past(top_reg.lbuf[c_word*DATA_W +: DATA_W]))
    else $error("present fill word not forwarded");

  one_address_a : assert property ((mem_rd_req && mem_rd_ack)
    |-> mem_rd_addr[OFF_W-1:0] == '0 ##1 !mem_rd_req [*4])
    else $error("extra address issued during burst");

  burst_four_a : assert property ((top_reg.st == ST_FILL && $past(top_reg.st) == ST_REQ)
    |-> top_reg.beat == '0 && top_reg.lmask == '0)
    else $error("burst did not start at beat zero");

  buffered_write_a : assert property ((c_v && c_we && top_reg.st == ST_IDLE)
    |-> wb_push && wb_in_ready ##1 !cpu_rsp_valid)
    else $error("write not buffered");

  wrap_order_a : assert property ((beat_v && top_reg.beat == 2'h1)
    |=> top_reg.lmask[$past(top_reg.miss_addr[WSEL_LSB +: WSEL_W]) + 2'h1])
    else $error("fill did not wrap from missed word");

  drain_before_miss_a : assert property (mem_rd_req
    |-> !mem_wr_valid && wb_cnt == '0)
    else $error("block read issued before writes drained");

  no_early_ready_a : assert property ((top_reg.st == ST_REQ || top_reg.st == ST_DRAIN)
    |-> !cpu_req_ready)
    else $error("processor released before missed word");

  stall_fill_a : assert property ((take_cpu && !c_we && fill_match && !top_reg.lmask[c_word])
    |=> top_reg.pend_v && !cpu_req_ready)
    else $error("absent fill word not stalled");

  fill_hit_a : assert property ((top_reg.st == ST_FILL && take_cpu && !c_we && !fill_match && hit)
    |=> cpu_rsp_valid && cpu_rsp_rdata == $past(dir_rd_data[c_word*DATA_W +: DATA_W]))
    else $error("hit during fill not answered");

  hit_answer_a : assert property ((top_reg.st == ST_IDLE && c_v && !c_we && hit)
    |=> cpu_rsp_valid && cpu_rsp_rdata == $past(dir_rd_data[c_word*DATA_W +: DATA_W]))
    else $error("read hit not answered next cycle");

  write_release_a : assert property ((top_reg.st == ST_IDLE && c_v && c_we && wb_cnt < 5'h0F)
    |=> cpu_req_ready)
    else $error("processor held after buffered write");

endmodule : cmf_cache_fill
`default_nettype wire

//--- test/cmf_mem_model.sv
// main memory partner: wrapped block read bursts and a write port that may stall
`timescale 1ns/1ps
`default_nettype none
module cmf_mem_model
  import cmf_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       hold_wr,
  input  wire logic                       mem_rd_req,
  input  wire logic [cmf_pkg::ADDR_W-1:0] mem_rd_addr,
  input  wire logic [cmf_pkg::WSEL_W-1:0] mem_rd_word,
  output var  logic                       mem_rd_ack,
  output var  logic                       mem_rd_valid,
  output var  logic [cmf_pkg::DATA_W-1:0] mem_rd_data,
  input  wire logic                       mem_wr_valid,
  input  wire logic [cmf_pkg::ADDR_W-1:0] mem_wr_addr,
  input  wire logic [cmf_pkg::DATA_W-1:0] mem_wr_data,
  output var  logic                       mem_wr_ready
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] base;
  logic [1:0]  word;
  int          beats;

  // untouched locations read as a pattern of their own address
  function automatic logic [31:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : ~a ^ 32'h5A5A_0000;
  endfunction : rd

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_rd_ack <= 1'b0;
      mem_rd_valid <= 1'b0;
      mem_rd_data <= 32'h0;
      mem_wr_ready <= 1'b0;
      beats = 4;
    end
    else
    begin
      mem_rd_valid <= 1'b0;
      // data line changes between beats so a late sample never looks right
      mem_rd_data <= $urandom;
      if (mem_rd_ack)
      begin
        mem_rd_ack <= 1'b0;
        base = mem_rd_addr; // one address per block
        word = mem_rd_word;
        beats = 0;
      end
      else if (mem_rd_req && beats == 4 && $urandom_range(2) == 0)
        mem_rd_ack <= 1'b1;
      else if (beats < 4 && $urandom_range(1) == 0)
      begin
        mem_rd_valid <= 1'b1; // four words after one address
        mem_rd_data <= rd({base[31:4], word + 2'(beats), 2'b00}); // wrap from missed word
        beats++;
      end
      mem_wr_ready <= !hold_wr && $urandom_range(3) != 0;
      if (mem_wr_valid && mem_wr_ready)
        mem[mem_wr_addr] = mem_wr_data; // write lands while the cpu runs on
    end
  end
endmodule : cmf_mem_model
`default_nettype wire

//--- test/cmf_cache_fill_test.sv
// self-checking bench for the cache miss fill block
`timescale 1ns/1ps
`default_nettype none
module cmf_cache_fill_test;
  import cmf_pkg::*;
  logic        clk, nrst, hold_wr;
  logic        cpu_req_valid, cpu_req_write, cpu_req_ready, cpu_rsp_valid;
  logic [31:0] cpu_req_addr, cpu_req_wdata, cpu_rsp_rdata;
  logic        mem_rd_req, mem_rd_ack, mem_rd_valid, mem_wr_valid, mem_wr_ready;
  logic [31:0] mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data;
  logic [1:0]  mem_rd_word;
  logic [31:0] shadow [logic [31:0]];
  logic [31:0] eq[$];
  logic [31:0] rq[$];
  logic [63:0] wq[$];
  int          n_fail, num_checks, cyc, fills, beats, first, wt, mx, f, i;

  cmf_cache_fill u_cmf_cache_fill (.clk(clk), .nrst(nrst), .cpu_req_valid(cpu_req_valid),
    .cpu_req_write(cpu_req_write), .cpu_req_addr(cpu_req_addr), .cpu_req_wdata(cpu_req_wdata),
    .cpu_req_ready(cpu_req_ready), .cpu_rsp_valid(cpu_rsp_valid), .cpu_rsp_rdata(cpu_rsp_rdata),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_word(mem_rd_word), .mem_rd_ack(mem_rd_ack),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready));

  cmf_mem_model u_cmf_mem_model (.clk(clk), .nrst(nrst), .hold_wr(hold_wr), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_word(mem_rd_word), .mem_rd_ack(mem_rd_ack),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready));

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    return shadow.exists(a) ? shadow[a] : ~a ^ 32'h5A5A_0000;
  endfunction : exp_rd

  function automatic logic pending_word();
    foreach (rq[k])
      if (rq[k][31:4] == mem_rd_addr[31:4] && rq[k][3:2] == mem_rd_word)
        return 1'b1;
    return 1'b0;
  endfunction : pending_word

  // request is held from a falling edge until the rising edge that sees ready
  task automatic req(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    cpu_req_valid = 1'b1;
    cpu_req_write = w;
    cpu_req_addr = a;
    cpu_req_wdata = d;
    wt = 0;
    while (cpu_req_ready !== 1'b1 && wt < 300)
    begin
      @(negedge clk);
      wt++;
    end
    chk("request taken", 1, cpu_req_ready);
    @(posedge clk);
    if (w)
    begin
      shadow[a] = d;
      wq.push_back({a, d});
    end
    else
    begin
      eq.push_back(exp_rd(a));
      rq.push_back(a);
    end
  endtask : req

  task automatic idle(input int n);
    @(negedge clk);
    cpu_req_valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic settle();
    int n;
    n = 0;
    while ((eq.size() != 0 || wq.size() != 0 || beats < 4) && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    chk("settled in time", 1, n < 2000);
    repeat (3) @(negedge clk);
  endtask : settle

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  always @(negedge clk)
    if (nrst && cpu_rsp_valid === 1'b1)
    begin
      chk("read data", eq.size() ? eq.pop_front() : 64'h1_0000_0000, cpu_rsp_rdata);
      if (rq.size())
        void'(rq.pop_front());
    end

  always @(posedge clk)
    if (nrst)
    begin
      if (first == 1)
      begin
        chk("bypass response", 1, cpu_rsp_valid);
        chk("ready after bypass", 1, cpu_req_ready);
      end
      first = 0;
      if (beats < 4)
        chk("no address during burst", 0, mem_rd_req);
      if (mem_rd_req === 1'b1 && mem_rd_ack === 1'b1)
      begin
        chk("block address low bits", 0, mem_rd_addr[3:0]);
        chk("missed word first", 1, pending_word());
        fills++;
        beats = 0;
      end
      else if (mem_rd_valid === 1'b1 && beats < 4)
      begin
        first = (beats == 0);
        beats++;
      end
      if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1)
        chk("memory write", wq.size() ? wq.pop_front() : 64'h0, {mem_wr_addr, mem_wr_data});
    end

  initial
  begin
    nrst = 1'b0;
    hold_wr = 1'b0;
    cpu_req_valid = 1'b0;
    cpu_req_write = 1'b0;
    cpu_req_addr = 32'h0;
    cpu_req_wdata = 32'h0;
    beats = 4;
    void'($urandom(32'hFBA790A1));
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    // miss on word 2, then the next word while the block is still arriving
    req(0, 32'h0000_0058, 32'h0);
    req(0, 32'h0000_005C, 32'h0);
    req(0, 32'h0000_0050, 32'h0);
    idle(0);
    settle();
    f = fills;
    req(0, 32'h0000_0058, 32'h0);
    idle(0);
    chk("hit answers next cycle", 1, cpu_rsp_valid);
    settle();
    chk("filled block kept with its tag", f, fills);
    req(0, 32'h0000_0158, 32'h0);
    // the old block still hits until this fill lands
    idle(0);
    settle();
    req(0, 32'h0000_0058, 32'h0);
    idle(0);
    settle();
    chk("conflicting tag refetches", f + 2, fills);
    $display("test miss_bypass done");
    // memory stalls writes for a while so the buffer fills and refuses
    hold_wr = 1'b1;
    fork
      begin
        repeat (60) @(negedge clk);
        hold_wr = 1'b0;
      end
    join_none
    mx = 0;
    for (i = 0; i < 20; i++)
    begin
      req(1, 32'h0000_0400 + 32'(i * 4), $urandom);
      if (i < 8)
        chk("write at cache speed", 0, 64'(wt));
      if (wt > mx)
        mx = wt;
    end
    chk("full buffer refuses", 1, mx > 0);
    idle(0);
    settle();
    req(0, 32'h0000_0404, 32'h0);
    idle(0);
    settle();
    $display("test write_buffer done");
    for (i = 0; i < 400; i++)
    begin
      req($urandom_range(2) == 0, {22'h0, 2'($urandom_range(2)), 4'($urandom), 2'($urandom), 2'b00}, $urandom);
      if ($urandom_range(3) == 0)
        idle($urandom_range(3));
    end
    idle(0);
    settle();
    chk("all answered", 0, eq.size());
    $display("test random_mix done");
    finish_test();
  end
endmodule : cmf_cache_fill_test
`default_nettype wire
